// *** logic/pcdio_regs.vh ***
/*
 Constants for the pump controller discrete I/O block: register offsets,
 field positions, reset values, mode codes and timing counts.
 Assumes a 20 MHz APB clock and 32-bit aligned register words.
*/
// Functional notes
// RL1: PLC drives inputs only when ready, unfaulted
// RL2: System trigger ignored in prime or agitate
// RL3: Dispense: trigger edge starts all eligible channels
// RL4: Skip disabled, faulted or unreferenced channels
// RL5: Disabled channel stays ported to inlet
// RL6: Meter pumps while trigger held, until empty
// RL7: System ready only when all channels ready
// RL8: System fault output true when no faults
// RL9: System load out false while any needs load
// RL10: Load rising edge starts load, ignore until done
// RL11: Channel trigger works in dispense or meter only
// RL12: Channel trigger refused in setup/prime/agitate/fault/ref/load
// RL13: Channel ready shows idle, sense selectable
// RL14: Channel fault output low while faulted
// RL15: Channel load out low while load needed/running
// RL16: Channel load edge starts load, ignore until done
// RL17: Prime runs until stop or duration timeout
// RL18: Prime volume not added to totalizer
// RL19: Dispense runs to volume unless stopped
// RL20: MCV mode change forces a load cycle
// RL21: Meter starts and stops with hardwired level
// RL22: Agitate only by serial begin and end
// RL23: Inputs synchronised and edge detected
`ifndef PCDIO_REGS_VH
`define PCDIO_REGS_VH

`define PCDIO_NCH 4
// Register byte offsets
`define PCDIO_CTRL_OFF 12'h000
`define PCDIO_CHEN_OFF 12'h004
`define PCDIO_CHFLT_OFF 12'h008
`define PCDIO_CMD_OFF 12'h00C
`define PCDIO_VOL_OFF 12'h010
`define PCDIO_PRIME_OFF 12'h014
`define PCDIO_STAT_OFF 12'h018
`define PCDIO_TOTAL_OFF 12'h01C
// CTRL fields
`define PCDIO_CTRL_MODE_LSB 0
`define PCDIO_CTRL_RDYINV_BIT 4
`define PCDIO_CTRL_CHSEL_LSB 8
`define PCDIO_CTRL_RST 32'h00000000
// CMD bits: write one to act
`define PCDIO_CMD_START 0
`define PCDIO_CMD_STOP 1
`define PCDIO_CMD_BEGIN 2
`define PCDIO_CMD_END 3
`define PCDIO_CMD_REF 4
`define PCDIO_CMD_CLRFLT 5
`define PCDIO_CMD_LOAD 6
`define PCDIO_CMD_CLRTOT 7
`define PCDIO_CMD_SETFLT 8
// Mode codes
`define PCDIO_MODE_SETUP 3'h0
`define PCDIO_MODE_PRIME 3'h1
`define PCDIO_MODE_DISP 3'h2
`define PCDIO_MODE_MCV 3'h3
`define PCDIO_MODE_METER 3'h4
`define PCDIO_MODE_AGIT 3'h5
// Reset values
`define PCDIO_VOL_RST 16'h0010
`define PCDIO_PRIME_RST 16'h0064
`define PCDIO_CHAMBER 16'h0100
// One volume unit per tick; tick every 1 ms
`define PCDIO_TICK_NS 1000000
`define PCDIO_CLK_NS 50
`define PCDIO_TICK_CYC (`PCDIO_TICK_NS / `PCDIO_CLK_NS)
`define PCDIO_LOAD_TICKS 16'h0008

`endif

// *** logic/pcdio_top.v ***
/*
 PLC discrete handshake, channel state machines and APB registers of a
 four-channel pump controller.
 Assumes PLC inputs are asynchronous levels and one 20 MHz clock.
*/
`timescale 1ns/1ps
`include "pcdio_regs.vh"
`default_nettype none

module pcdio_top #(
    parameter TICK_CYC = `PCDIO_TICK_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sys_trig_in,
    input wire sys_load_in,
    input wire ch_trig_in,
    input wire ch_load_in,
    output reg sys_ready_out,
    output reg sys_fault_n_out,
    output reg sys_load_ok_out,
    output reg ch_ready_out,
    output reg ch_fault_n_out,
    output reg ch_load_ok_out,
    output reg [3:0] ch_pump_out,
    output reg [3:0] ch_inlet_out
);
    localparam NCH = `PCDIO_NCH;
    // Channel states, one-hot
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_PUMP = 4'h2;
    localparam [3:0] ST_LOAD = 4'h4;
    localparam [3:0] ST_REF = 4'h8;

    // Mode tests reused for both triggers
    function trig_mode;
        input [2:0] m;
        begin
            trig_mode = (m == `PCDIO_MODE_DISP) || (m == `PCDIO_MODE_MCV) ||
                (m == `PCDIO_MODE_METER);
        end
    endfunction

    function is_meter;
        input [2:0] m;
        begin
            is_meter = (m == `PCDIO_MODE_METER);
        end
    endfunction

    // Registers
    reg [31:0] ctrl_reg;
    reg [3:0] chen_reg;
    reg [15:0] vol_reg;
    reg [15:0] prime_reg;
    reg [31:0] total_reg;
    reg [3:0] fault_reg;
    reg [3:0] unref_reg;
    reg [3:0] need_load_reg;
    reg [3:0] st_reg [0:NCH-1];
    reg [15:0] cnt_reg [0:NCH-1];
    reg [15:0] level_reg [0:NCH-1];
    reg [3:0] sync1_reg;
    reg [3:0] sync2_reg;
    reg [3:0] prev_reg;
    reg [19:0] div_reg;
    reg tick_reg;
    reg sys_load_busy_reg;
    reg ch_load_busy_reg;
    reg agit_reg;

    wire [2:0] mode = ctrl_reg[`PCDIO_CTRL_MODE_LSB+2:`PCDIO_CTRL_MODE_LSB];
    wire rdy_inv = ctrl_reg[`PCDIO_CTRL_RDYINV_BIT];
    wire [1:0] chsel = ctrl_reg[`PCDIO_CTRL_CHSEL_LSB+1:`PCDIO_CTRL_CHSEL_LSB];
    wire wr = psel && penable && pwrite;
    wire cmd_wr = wr && (paddr == `PCDIO_CMD_OFF);
    wire [8:0] cmd = cmd_wr ? pwdata[8:0] : 9'h000;

    // Two flops then edge detect [RL23]
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            prev_reg <= 4'h0;
        end else begin
            sync1_reg <= {ch_load_in, ch_trig_in, sys_load_in, sys_trig_in};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    wire sys_trig = sync2_reg[0];
    wire sys_trig_rise = sync2_reg[0] && !prev_reg[0];
    wire sys_load_rise = sync2_reg[1] && !prev_reg[1];
    wire ch_trig = sync2_reg[2];
    wire ch_trig_rise = sync2_reg[2] && !prev_reg[2];
    wire ch_load_rise = sync2_reg[3] && !prev_reg[3];

    // 1 ms tick paces volume and prime time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 20'h00000;
            tick_reg <= 1'b0;
        end else if (div_reg == TICK_CYC - 1) begin
            div_reg <= 20'h00000;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 20'h00001;
            tick_reg <= 1'b0;
        end
    end

    // Only serial begin/end moves agitate [RL22]
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agit_reg <= 1'b0;
        end else if (mode != `PCDIO_MODE_AGIT || cmd[`PCDIO_CMD_END]) begin
            agit_reg <= 1'b0;
        end else if (cmd[`PCDIO_CMD_BEGIN]) begin
            agit_reg <= 1'b1;
        end
    end

    // Load edges wait out a running load
    reg [3:0] loading_v;
    integer k;
    always @* begin
        loading_v = 4'h0;
        for (k = 0; k < NCH; k = k + 1) begin
            loading_v[k] = (st_reg[k] == ST_LOAD);
        end
    end
    wire any_loading_w = |loading_v;
    wire sys_load_go = sys_load_rise && !sys_load_busy_reg; // [RL10]
    wire ch_load_go = ch_load_rise && !ch_load_busy_reg; // [RL16]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_load_busy_reg <= 1'b0;
            ch_load_busy_reg <= 1'b0;
        end else begin
            // Busy drops when the load ends
            if (sys_load_go) begin
                sys_load_busy_reg <= 1'b1;
            end else if (!any_loading_w) begin
                sys_load_busy_reg <= 1'b0; // [RL10]
            end
            if (ch_load_go) begin
                ch_load_busy_reg <= 1'b1;
            end else if (!loading_v[chsel]) begin
                ch_load_busy_reg <= 1'b0; // [RL16]
            end
        end
    end

    // Changing into or out of MCV forces a reload
    reg [2:0] mode_prev_reg;
    wire mcv_change = (mode == `PCDIO_MODE_MCV) !=
        (mode_prev_reg == `PCDIO_MODE_MCV);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_prev_reg <= `PCDIO_MODE_SETUP;
        end else begin
            mode_prev_reg <= mode;
        end
    end

    // Per-channel motion state machines
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            wire en = chen_reg[g];
            wire ok = en && !fault_reg[g] && !unref_reg[g]; // [RL4]
            // System trigger: dispense edge or meter level [RL2] [RL3] [RL6]
            wire sys_go = ok && trig_mode(mode) && !need_load_reg[g] &&
                (is_meter(mode) ? sys_trig : sys_trig_rise);
            // Channel trigger only in dispense/meter modes [RL11] [RL12]
            wire ch_go = ok && (chsel == g) && trig_mode(mode) &&
                !need_load_reg[g] &&
                (is_meter(mode) ? ch_trig : ch_trig_rise);
            wire sw_go = ok && cmd[`PCDIO_CMD_START] &&
                (trig_mode(mode) || mode == `PCDIO_MODE_PRIME);
            wire ld_go = ok &&
                (sys_load_go || (ch_load_go && chsel == g) ||
                cmd[`PCDIO_CMD_LOAD]);
            wire hold = is_meter(mode) && (sys_trig || ch_trig && chsel == g);
            wire empty = (level_reg[g] == 16'h0000);

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st_reg[g] <= ST_REF;
                    cnt_reg[g] <= 16'h0000;
                    level_reg[g] <= 16'h0000;
                    need_load_reg[g] <= 1'b1;
                end else begin
                    if (mcv_change && en) begin
                        need_load_reg[g] <= 1'b1; // [RL20]
                    end
                    case (st_reg[g])
                        ST_IDLE: begin
                            cnt_reg[g] <= 16'h0000;
                            if (ld_go) begin
                                st_reg[g] <= ST_LOAD;
                            end else if (sys_go || ch_go || sw_go) begin
                                st_reg[g] <= ST_PUMP;
                            end
                        end
                        ST_PUMP: begin
                            if (tick_reg && !empty) begin
                                cnt_reg[g] <= cnt_reg[g] + 16'h0001;
                                level_reg[g] <= level_reg[g] - 16'h0001;
                            end
                            if (cmd[`PCDIO_CMD_STOP] || fault_reg[g]) begin
                                st_reg[g] <= ST_IDLE; // [RL17] [RL19]
                            end else if (mode == `PCDIO_MODE_PRIME) begin
                                if (cnt_reg[g] >= prime_reg) begin
                                    st_reg[g] <= ST_IDLE; // [RL17]
                                end
                            end else if (is_meter(mode)) begin
                                // Stops at once, reference ignored [RL21] [RL6]
                                if (!hold || empty) begin
                                    st_reg[g] <= ST_IDLE;
                                end
                            end else if (cnt_reg[g] >= vol_reg || empty) begin
                                st_reg[g] <= ST_IDLE; // [RL19]
                                if (empty) begin
                                    need_load_reg[g] <= 1'b1;
                                end
                            end
                        end
                        ST_LOAD: begin
                            if (tick_reg) begin
                                cnt_reg[g] <= cnt_reg[g] + 16'h0001;
                            end
                            if (cnt_reg[g] >= `PCDIO_LOAD_TICKS) begin
                                st_reg[g] <= ST_IDLE;
                                cnt_reg[g] <= 16'h0000;
                                need_load_reg[g] <= 1'b0;
                                // MCV fills only what one dispense needs
                                level_reg[g] <= (mode == `PCDIO_MODE_MCV) ?
                                    vol_reg : `PCDIO_CHAMBER;
                            end
                        end
                        ST_REF: begin
                            if (cmd[`PCDIO_CMD_REF] && !fault_reg[g]) begin
                                st_reg[g] <= ST_IDLE;
                            end
                        end
                        default: st_reg[g] <= ST_REF;
                    endcase
                end
            end
        end
    endgenerate

    // Fault and reference bookkeeping; a raise beats a clear
    integer f;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_reg <= 4'h0;
            unref_reg <= 4'hF;
        end else begin
            for (f = 0; f < NCH; f = f + 1) begin
                if (cmd[`PCDIO_CMD_SETFLT] && pwdata[16+f]) begin
                    fault_reg[f] <= 1'b1;
                    unref_reg[f] <= 1'b1;
                end else begin
                    if (cmd[`PCDIO_CMD_CLRFLT]) begin
                        fault_reg[f] <= 1'b0;
                    end
                    if (cmd[`PCDIO_CMD_REF] && !fault_reg[f]) begin
                        unref_reg[f] <= 1'b0;
                    end
                end
            end
        end
    end

    // Totaliser: only dispense and meter pumping counts [RL18]
    reg [3:0] pumping_v;
    integer p;
    always @* begin
        pumping_v = 4'h0;
        for (p = 0; p < NCH; p = p + 1) begin
            pumping_v[p] = (st_reg[p] == ST_PUMP) && level_reg[p] != 16'h0000;
        end
    end
    wire count_on = tick_reg && trig_mode(mode);
    wire [2:0] pump_n = {2'b00, pumping_v[0]} + {2'b00, pumping_v[1]} +
        {2'b00, pumping_v[2]} + {2'b00, pumping_v[3]};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_reg <= 32'h00000000;
        end else if (count_on) begin
            total_reg <= total_reg + {29'h0, pump_n}; // [RL18]
        end else if (cmd[`PCDIO_CMD_CLRTOT]) begin
            total_reg <= 32'h00000000;
        end
    end

    // Status feeding the PLC outputs
    reg [3:0] idle_v;
    reg [3:0] load_need_v;
    integer a;
    always @* begin
        idle_v = 4'h0;
        load_need_v = 4'h0;
        for (a = 0; a < NCH; a = a + 1) begin
            idle_v[a] = (st_reg[a] == ST_IDLE) || !chen_reg[a];
            load_need_v[a] = chen_reg[a] &&
                (need_load_reg[a] || st_reg[a] == ST_LOAD);
        end
    end

    // Outputs registered so the opto drivers see clean levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_ready_out <= 1'b0;
            sys_fault_n_out <= 1'b1;
            sys_load_ok_out <= 1'b0;
            ch_ready_out <= 1'b0;
            ch_fault_n_out <= 1'b1;
            ch_load_ok_out <= 1'b0;
            ch_pump_out <= 4'h0;
            ch_inlet_out <= 4'hF;
        end else begin
            sys_ready_out <= (&idle_v) ^ rdy_inv; // [RL7]
            sys_fault_n_out <= ~(|fault_reg); // [RL8]
            sys_load_ok_out <= ~(|load_need_v); // [RL9]
            ch_ready_out <= idle_v[chsel] ^ rdy_inv; // [RL13]
            ch_fault_n_out <= ~fault_reg[chsel]; // [RL14]
            ch_load_ok_out <= ~load_need_v[chsel]; // [RL15]
            for (a = 0; a < NCH; a = a + 1) begin
                ch_pump_out[a] <= (st_reg[a] == ST_PUMP) && chen_reg[a];
                // Disabled channels stay ported to the inlet [RL5]
                ch_inlet_out[a] <= !chen_reg[a] || st_reg[a] == ST_LOAD;
            end
        end
    end

    // APB slave: zero wait states, unmapped reads zero with pslverr
    reg [31:0] rd_v;
    reg hit_v;
    always @* begin
        hit_v = 1'b1;
        case (paddr)
            `PCDIO_CTRL_OFF: rd_v = ctrl_reg;
            `PCDIO_CHEN_OFF: rd_v = {28'h0, chen_reg};
            `PCDIO_CHFLT_OFF: rd_v = {24'h0, unref_reg, fault_reg};
            `PCDIO_CMD_OFF: rd_v = {31'h0, agit_reg};
            `PCDIO_VOL_OFF: rd_v = {16'h0, vol_reg};
            `PCDIO_PRIME_OFF: rd_v = {16'h0, prime_reg};
            `PCDIO_STAT_OFF: rd_v = {12'h0, need_load_reg, st_reg[3],
                st_reg[2], st_reg[1], st_reg[0]};
            `PCDIO_TOTAL_OFF: rd_v = total_reg;
            default: begin
                rd_v = 32'h00000000;
                hit_v = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `PCDIO_CTRL_RST;
            chen_reg <= 4'hF;
            vol_reg <= `PCDIO_VOL_RST;
            prime_reg <= `PCDIO_PRIME_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_v;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_v;
            end
            if (wr && pready) begin
                case (paddr)
                    `PCDIO_CTRL_OFF: ctrl_reg <= pwdata;
                    `PCDIO_CHEN_OFF: chen_reg <= pwdata[3:0];
                    `PCDIO_VOL_OFF: vol_reg <= pwdata[15:0];
                    `PCDIO_PRIME_OFF: prime_reg <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end
endmodule // pcdio_top
`default_nettype wire

// *** bench/pcdio_assertions.sv ***
/*
 Port checker for pcdio_top, bound in from the testbench.
 Assumes writes land at the APB access edge.
*/
`timescale 1ns/1ps
`include "pcdio_regs.vh"
`default_nettype none

module pcdio_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire sys_trig_in,
    input wire ch_trig_in,
    input wire sys_ready_out,
    input wire sys_fault_n_out,
    input wire sys_load_ok_out,
    input wire ch_fault_n_out,
    input wire ch_load_ok_out,
    input wire [3:0] ch_pump_out,
    input wire [3:0] ch_inlet_out
);
    reg [2:0] mode_reg;
    reg inv_reg;
    reg [3:0] chen_reg;
    reg [1:0] sel_reg;
    wire wr_acc = psel && penable && pready && pwrite;

    // Shadow of CTRL and CHEN writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= 3'h0;
            inv_reg <= 1'b0;
            chen_reg <= 4'hF;
            sel_reg <= 2'h0;
        end else if (wr_acc && paddr == `PCDIO_CTRL_OFF) begin
            mode_reg <= pwdata[2:0];
            inv_reg <= pwdata[4];
            sel_reg <= pwdata[9:8];
        end else if (wr_acc && paddr == `PCDIO_CHEN_OFF) begin
            chen_reg <= pwdata[3:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Outputs lag state by one cycle
    property p_setup; psel && !penable |=> pready; endproperty
    a_setup: assert property (p_setup)
        else $error("pready missing after setup");
    property p_access; pready |-> psel && penable; endproperty
    a_access: assert property (p_access)
        else $error("pready outside access phase");
    property p_ready; (|ch_pump_out && !inv_reg)[*3] |-> !sys_ready_out;
    endproperty
    a_ready: assert property (p_ready)
        else $error("system ready while a channel pumps");
    property p_trig_off;
        (mode_reg == `PCDIO_MODE_PRIME || mode_reg == `PCDIO_MODE_AGIT) &&
        $rose(sys_trig_in) && ch_pump_out == 4'h0
        |=> (ch_pump_out == 4'h0)[*6];
    endproperty
    a_trig_off: assert property (p_trig_off)
        else $error("trigger started pumping in prime or agitate");
    property p_disabled; chen_reg == $past(chen_reg, 2) |->
        (~chen_reg & (~ch_inlet_out | ch_pump_out)) == 4'h0;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled channel left inlet or moved");
    property p_fault; !ch_fault_n_out |-> !sys_fault_n_out; endproperty
    a_fault: assert property (p_fault)
        else $error("channel faulted but system fault output high");
    property p_load;
        !ch_load_ok_out && chen_reg[sel_reg] && $stable(sel_reg)
        |-> !sys_load_ok_out;
    endproperty
    a_load: assert property (p_load)
        else $error("channel needs load but system load output high");
    property p_meter;
        (mode_reg == `PCDIO_MODE_METER && !sys_trig_in && !ch_trig_in &&
        sys_load_ok_out)[*8] |-> ch_pump_out == 4'h0;
    endproperty
    a_meter: assert property (p_meter)
        else $error("meter pumping with trigger removed");
endmodule // pcdio_chk
`default_nettype wire

// *** bench/pcdio_plc.sv ***
/*
 PLC model driving the four request lines of pcdio_top.
 Assumes drive() is called right after a rising pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pcdio_plc (
    input wire logic pclk,
    input wire logic ready_in,
    input wire logic fault_n_in,
    output logic [3:0] lines
);
    // Bit 0 system trigger, 1 system load, 2 channel trigger, 3 channel load
    initial begin
        lines = 4'h0;
    end

    // insist skips the ready wait so refusals show
    task automatic drive(input int line, input int hold, input bit insist);
        int n;
        n = 0;
        while (!insist && n < 100 &&
               !(ready_in === 1'b1 && fault_n_in === 1'b1)) begin
            @(posedge pclk);
            n++;
        end
        if (n < 100) begin
            lines[line] <= 1'b1;
            repeat (hold) @(posedge pclk);
            lines[line] <= 1'b0;
        end else begin
            tb.miscompares++;
            tb.summarize();
        end
    endtask
endmodule // pcdio_plc
`default_nettype wire

// *** bench/tb.sv ***
/*
 Self-checking bench for pcdio_top: APB task, PLC partner, scenarios.
 Assumes a 20 MHz pclk and TICK_CYC cut to 4 so ticks stay short.
*/
`timescale 1ns/1ps
`include "pcdio_regs.vh"
`default_nettype none

module tb;
    logic pclk, presetn, psel, penable, pwrite, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, t1;
    wire [31:0] prdata;
    wire pready, pslverr, sys_ready_out, sys_fault_n_out, sys_load_ok_out;
    wire ch_ready_out, ch_fault_n_out, ch_load_ok_out;
    wire [3:0] ch_pump_out, ch_inlet_out, plc;
    int miscompares, tests_run, n;

    // Free-running 50 ns clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    pcdio_top #(.TICK_CYC(4)) u_pcdio_top (.*, .sys_trig_in(plc[0]),
        .sys_load_in(plc[1]), .ch_trig_in(plc[2]), .ch_load_in(plc[3]));
    pcdio_plc u_pcdio_plc (.pclk(pclk), .ready_in(sys_ready_out),
        .fault_n_in(sys_fault_n_out), .lines(plc));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) miscompares++;
        if (k >= 16) summarize();
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [3:0] obs(input int k);
        case (k)
            0: return ch_pump_out;
            1: return {3'h0, sys_load_ok_out};
            2: return {3'h0, sys_fault_n_out};
            3: return {3'h0, ch_load_ok_out};
            default: return {3'h0, ch_ready_out};
        endcase
    endfunction

    // Bounded wait; n counts edges
    task automatic wait_for(input int k, input logic [3:0] x, input int b);
        n = 0;
        while (obs(k) !== x && n < b) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(obs(k)), 32'(x));
        if (obs(k) !== x) summarize();
    endtask

    task automatic stays(input int k, input logic [3:0] x, input int c);
        logic ok;
        ok = 1'b1;
        repeat (c) begin
            @(posedge pclk);
            if (obs(k) !== x) ok = 1'b0;
        end
        chk(32'(ok), 32'h1);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge pclk);
        miscompares++;
        summarize();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        miscompares = 0;
        tests_run = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(sys_fault_n_out), 32'h1);
        chk(32'(sys_load_ok_out), 32'h0);
        bus(1'b0, `PCDIO_CHFLT_OFF, 32'h0);
        chk(rd, 32'hF0);
        bus(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], e}, 32'h1);
        $display("test reset done");
        // Reference all, then one system load
        bus(1'b1, `PCDIO_CMD_OFF, 32'h10);
        n = 0;
        do begin
            bus(1'b0, `PCDIO_CHFLT_OFF, 32'h0);
            n++;
        end while (rd !== 32'h0 && n < 50);
        chk(rd, 32'h0);
        u_pcdio_plc.drive(1, 2, 1'b0);
        wait_for(1, 4'h1, 200);
        chk(32'(n > 25 && n < 46), 32'h1);
        $display("test load done");
        // Dispense with channel 1 disabled
        bus(1'b1, `PCDIO_CHEN_OFF, 32'hD);
        bus(1'b1, `PCDIO_CTRL_OFF, 32'h2);
        u_pcdio_plc.drive(0, 2, 1'b0);
        wait_for(0, 4'hD, 20);
        chk(32'(ch_inlet_out[1]), 32'h1);
        chk(32'(sys_ready_out), 32'h0);
        wait_for(0, 4'h0, 100);
        chk(32'(n > 56 && n < 72), 32'h1);
        bus(1'b0, `PCDIO_TOTAL_OFF, 32'h0);
        t1 = rd;
        chk(32'(t1 != 32'h0), 32'h1);
        $display("test dispense done");
        // Meter follows the trigger level
        bus(1'b1, `PCDIO_CTRL_OFF, 32'h4);
        fork
            u_pcdio_plc.drive(0, 40, 1'b0);
            begin
                wait_for(0, 4'hD, 20);
                stays(0, 4'hD, 25);
            end
        join
        wait_for(0, 4'h0, 8);
        bus(1'b0, `PCDIO_TOTAL_OFF, 32'h0);
        chk(32'(rd > t1), 32'h1);
        t1 = rd;
        $display("test meter done");
        // Prime ignores trigger, times out
        bus(1'b1, `PCDIO_PRIME_OFF, 32'h4);
        bus(1'b1, `PCDIO_CTRL_OFF, 32'h1);
        u_pcdio_plc.drive(0, 2, 1'b0);
        stays(0, 4'h0, 20);
        bus(1'b1, `PCDIO_CMD_OFF, 32'h1);
        wait_for(0, 4'hD, 10);
        wait_for(0, 4'h0, 40);
        bus(1'b0, `PCDIO_TOTAL_OFF, 32'h0);
        chk(rd, t1);
        bus(1'b1, `PCDIO_CTRL_OFF, 32'h5);
        u_pcdio_plc.drive(0, 2, 1'b0);
        stays(0, 4'h0, 20);
        $display("test prime done");
        // Fault on selected channel 2
        bus(1'b1, `PCDIO_CTRL_OFF, 32'h202);
        bus(1'b1, `PCDIO_CMD_OFF, 32'h40100);
        wait_for(2, 4'h0, 10);
        chk(32'(ch_fault_n_out), 32'h0);
        u_pcdio_plc.drive(2, 2, 1'b1);
        stays(0, 4'h0, 20);
        u_pcdio_plc.drive(0, 2, 1'b1);
        wait_for(0, 4'h9, 20);
        wait_for(0, 4'h0, 100);
        bus(1'b1, `PCDIO_CMD_OFF, 32'h20);
        wait_for(2, 4'h1, 10);
        bus(1'b0, `PCDIO_CHFLT_OFF, 32'h0);
        chk(rd, 32'h40);
        $display("test fault done");
        // Channel trigger refused in setup, taken in dispense
        bus(1'b1, `PCDIO_CTRL_OFF, 32'h0);
        u_pcdio_plc.drive(2, 2, 1'b0);
        stays(0, 4'h0, 20);
        bus(1'b1, `PCDIO_CTRL_OFF, 32'h2);
        u_pcdio_plc.drive(2, 2, 1'b0);
        wait_for(0, 4'h1, 20);
        wait_for(0, 4'h0, 100);
        $display("test channel done");
        // MCV entry demands a load
        bus(1'b1, `PCDIO_CTRL_OFF, 32'h3);
        wait_for(1, 4'h0, 20);
        wait_for(3, 4'h0, 5);
        u_pcdio_plc.drive(2, 2, 1'b0);
        stays(0, 4'h0, 20);
        u_pcdio_plc.drive(3, 2, 1'b0);
        repeat (8) @(posedge pclk);
        u_pcdio_plc.drive(3, 2, 1'b1);
        wait_for(3, 4'h1, 80);
        stays(3, 4'h1, 40);
        wait_for(4, 4'h1, 5);
        bus(1'b1, `PCDIO_CTRL_OFF, 32'h13);
        wait_for(4, 4'h0, 6);
        $display("test mcv done");
        summarize();
    end
endmodule // tb

bind pcdio_top pcdio_chk u_pcdio_chk (.*);
`default_nettype wire
